/* hw/ovh_pkg.sv */
package ovh_pkg;
  // overhead carried per frame: marker bit plus four control bits
  typedef struct packed {
    logic       mf;
    logic [3:0] ctl;
  } ovh_frame_t;
  typedef logic [15:0] ovh_word_t;
  typedef enum logic {RX_HUNT = 1'b0, RX_FILL = 1'b1} rx_state_t;

  localparam int        SLOT_W     = 4;
  localparam logic [1:0] SLOT_FIRST = 2'h0;
  localparam logic [1:0] SLOT_LAST  = 2'h3;
  localparam logic [3:0] MF_WORD    = 4'h8;
  // downstream word layout (network side sends)
  localparam int D_WAKE1   = 0;
  localparam int D_PERMIT1 = 1;
  localparam int D_DOWN1   = 2;
  localparam int D_SYNC    = 3;
  localparam int D_LREQ1   = 4;
  localparam int D_LREQ2   = 5;
  localparam int D_LREQ3   = 6;
  localparam int D_LCREQ1  = 7;
  localparam int D_WAKE3   = 8;
  localparam int D_PERMIT3 = 9;
  localparam int D_DOWN3   = 10;
  localparam int D_LCREQ2  = 11;
  localparam int D_SPARE   = 12;
  // upstream word layout (user side sends)
  localparam int U_UP1     = 0;
  localparam int U_FUT1    = 1;
  localparam int U_Q1      = 2;
  localparam int U_Q2      = 3;
  localparam int U_ACK1    = 4;
  localparam int U_ACK2    = 5;
  localparam int U_ACK3    = 6;
  localparam int U_LCACK1  = 7;
  localparam int U_UP3     = 8;
  localparam int U_FUT2    = 9;
  localparam int U_Q3      = 10;
  localparam int U_Q4      = 11;
  localparam int U_RBE     = 12;
  localparam int U_LCACK2  = 13;
  localparam ovh_word_t DN_IDLE = 16'h0000;
  localparam ovh_word_t UP_IDLE = 16'h0c0c;
  localparam ovh_word_t DN_LOSS = 16'h0000;
  localparam ovh_word_t UP_LOSS = 16'h0c0c;
  // register word index (byte address = 4 * index)
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_CMD    = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_RXCONF = 3'h3;
  localparam logic [2:0] REG_TXWORD = 3'h4;
  localparam int CTRL_ROLE  = 0;
  localparam int CMD_ACT    = 0;
  localparam int CMD_DEACT  = 1;
  localparam int CMD_GRANT  = 2;
  localparam int CMD_DOWN   = 3;
  localparam int CMD_L2ON   = 4;
  localparam int CMD_L2OFF  = 5;
endpackage

/* hw/line_overhead_maintenance_bits.sv */
`timescale 1ns/1ps
module line_overhead_maintenance_bits (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [4:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  input  wire logic               rx_frame_stb_i,
  input  wire ovh_pkg::ovh_frame_t rx_frame_i,
  input  wire logic               rx_frame_aligned_i,
  input  wire logic               crc_done_i,
  input  wire logic               crc_err_i,
  input  wire logic               tx_frame_stb_i,
  output ovh_pkg::ovh_frame_t     tx_frame_o,
  input  wire logic               info3_rx_i,
  input  wire logic               t_aligned_i,
  output logic                    send_info0_o,
  output logic                    send_info2_o,
  output logic                    send_info4_o,
  output logic                    loop2_active_o,
  output logic                    mf_locked_o
);

  function automatic ovh_pkg::ovh_word_t put_slot(input ovh_pkg::ovh_word_t w,
                                                  input logic [1:0] idx,
                                                  input logic [3:0] v);
    ovh_pkg::ovh_word_t r;
    r = w;
    r[idx*ovh_pkg::SLOT_W +: ovh_pkg::SLOT_W] = v;
    return r;
  endfunction

  function automatic logic [3:0] get_slot(input ovh_pkg::ovh_word_t w,
                                          input logic [1:0] idx);
    return w[idx*ovh_pkg::SLOT_W +: ovh_pkg::SLOT_W];
  endfunction

  logic                ack_ff;
  logic                role_net_ff;
  logic                wake_ff;
  logic                permit_ff;
  logic                down_ff;
  logic                loop2_req_ff;
  logic                rbe_ff;
  logic [1:0]          tx_cnt_ff;
  ovh_pkg::ovh_word_t  tx_word_ff;
  ovh_pkg::ovh_word_t  nxt_tx_word;
  ovh_pkg::ovh_frame_t tx_frame_ff;
  ovh_pkg::rx_state_t  rx_state_ff;
  logic [1:0]          rx_cnt_ff;
  logic [1:0]          loss_cnt_ff;
  ovh_pkg::ovh_word_t  rx_buf_ff;
  logic                mf_locked_ff;
  logic [3:0]          mf_hist_ff;
  logic                smp_vld_ff;
  logic                smp_loss_ff;
  ovh_pkg::ovh_word_t  smp_word_ff;
  ovh_pkg::ovh_word_t  h1_ff;
  ovh_pkg::ovh_word_t  h2_ff;
  ovh_pkg::ovh_word_t  conf_ff;
  ovh_pkg::ovh_word_t  loss_word;
  ovh_pkg::ovh_word_t  filt_eq;
  logic                loop2_act_ff;
  logic                info0_ff;
  logic                info2_ff;
  logic                info4_ff;
  logic                cf_wake;
  logic                cf_permit;
  logic                cf_down;
  logic                cf_sync;
  logic                cf_loop2;
  logic                cf_up;
  logic                cf_ack;
  logic                up_flag;
  logic                go_info0;
  logic                go_info4;
  logic                bus_req;
  logic                cmd_wr;
  logic [31:0]         rd_data;
  logic [31:0]         dat_ff;

  // register bus: one wait-free answer, ack one cycle after request
  assign bus_req = cyc_i & stb_i & ~ack_ff;
  assign cmd_wr  = bus_req & we_i & sel_i[0] & (adr_i[4:2] == ovh_pkg::REG_CMD);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (adr_i[4:2])
      ovh_pkg::REG_CTRL:   rd_data[ovh_pkg::CTRL_ROLE] = role_net_ff;
      ovh_pkg::REG_STATUS: rd_data[9:0] = {cf_ack, cf_up, rbe_ff, info4_ff, info2_ff,
                                           info0_ff, loop2_act_ff, loop2_req_ff,
                                           permit_ff, mf_locked_ff};
      ovh_pkg::REG_RXCONF: rd_data[15:0] = conf_ff;
      ovh_pkg::REG_TXWORD: rd_data[15:0] = tx_word_ff;
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (bus_req) begin
      dat_ff <= we_i ? 32'h0000_0000 : rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      role_net_ff <= 1'b0;
    end else if (bus_req && we_i && sel_i[0] && adr_i[4:2] == ovh_pkg::REG_CTRL) begin
      role_net_ff <= dat_i[ovh_pkg::CTRL_ROLE];
    end
  end

  // exchange requests, network side; a set in the same write wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_ff      <= 1'b0;
      permit_ff    <= 1'b0;
      down_ff      <= 1'b0;
      loop2_req_ff <= 1'b0;
    end else if (cmd_wr) begin
      if (dat_i[ovh_pkg::CMD_DEACT]) begin
        wake_ff   <= 1'b0;
        permit_ff <= 1'b0;
      end
      if (dat_i[ovh_pkg::CMD_ACT]) begin
        wake_ff <= 1'b1;
        down_ff <= 1'b0;
      end
      if (dat_i[ovh_pkg::CMD_GRANT]) begin
        permit_ff <= 1'b1;
      end
      if (dat_i[ovh_pkg::CMD_DOWN]) begin
        down_ff <= 1'b1;
      end
      if (dat_i[ovh_pkg::CMD_L2OFF]) begin
        loop2_req_ff <= 1'b0;
      end
      if (dat_i[ovh_pkg::CMD_L2ON]) begin
        loop2_req_ff <= 1'b1;
      end
    end
  end

  // latest crc verdict waits for the next outgoing multiframe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rbe_ff <= 1'b0;
    end else if (crc_done_i) begin
      rbe_ff <= crc_err_i;
    end
  end

  // transmit word: every field has fixed bits of its own, one to three copies each
  always_comb begin
    if (role_net_ff) begin
      nxt_tx_word = ovh_pkg::DN_IDLE;
      nxt_tx_word[ovh_pkg::D_SYNC]    = rx_frame_aligned_i;
      nxt_tx_word[ovh_pkg::D_WAKE1]   = wake_ff;
      nxt_tx_word[ovh_pkg::D_WAKE3]   = wake_ff;
      nxt_tx_word[ovh_pkg::D_PERMIT1] = permit_ff;
      nxt_tx_word[ovh_pkg::D_PERMIT3] = permit_ff;
      nxt_tx_word[ovh_pkg::D_DOWN1]   = down_ff;
      nxt_tx_word[ovh_pkg::D_DOWN3]   = down_ff;
      nxt_tx_word[ovh_pkg::D_LREQ1]   = loop2_req_ff;
      nxt_tx_word[ovh_pkg::D_LREQ2]   = loop2_req_ff;
      nxt_tx_word[ovh_pkg::D_LREQ3]   = loop2_req_ff;
    end else begin
      nxt_tx_word = ovh_pkg::UP_IDLE;
      nxt_tx_word[ovh_pkg::U_UP1]  = up_flag;
      nxt_tx_word[ovh_pkg::U_UP3]  = up_flag;
      nxt_tx_word[ovh_pkg::U_ACK1] = loop2_act_ff;
      nxt_tx_word[ovh_pkg::U_ACK2] = loop2_act_ff;
      nxt_tx_word[ovh_pkg::U_ACK3] = loop2_act_ff;
      nxt_tx_word[ovh_pkg::U_RBE]  = rbe_ff;
    end
  end

  // word is frozen at multiframe start so all four frames agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_cnt_ff   <= ovh_pkg::SLOT_FIRST;
      tx_word_ff  <= ovh_pkg::UP_IDLE;
      tx_frame_ff <= '0;
    end else if (tx_frame_stb_i) begin
      tx_cnt_ff <= tx_cnt_ff + 2'h1;
      tx_frame_ff.mf <= (tx_cnt_ff == ovh_pkg::SLOT_FIRST);
      if (tx_cnt_ff == ovh_pkg::SLOT_FIRST) begin
        tx_word_ff      <= nxt_tx_word;
        tx_frame_ff.ctl <= get_slot(nxt_tx_word, tx_cnt_ff);
      end else begin
        tx_frame_ff.ctl <= get_slot(tx_word_ff, tx_cnt_ff);
      end
    end
  end

  assign tx_frame_o = tx_frame_ff;
  assign loss_word  = role_net_ff ? ovh_pkg::UP_LOSS : ovh_pkg::DN_LOSS;

  // multiframe hunt and collect; one sample per multiframe period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_ff  <= ovh_pkg::RX_HUNT;
      rx_cnt_ff    <= ovh_pkg::SLOT_FIRST;
      loss_cnt_ff  <= ovh_pkg::SLOT_FIRST;
      rx_buf_ff    <= '0;
      mf_locked_ff <= 1'b0;
      mf_hist_ff   <= 4'h0;
      smp_vld_ff   <= 1'b0;
      smp_loss_ff  <= 1'b0;
      smp_word_ff  <= ovh_pkg::DN_LOSS;
    end else begin
      smp_vld_ff <= 1'b0;
      if (rx_frame_stb_i) begin
        mf_hist_ff <= {mf_hist_ff[2:0], rx_frame_i.mf};
        case (rx_state_ff)
          ovh_pkg::RX_HUNT: begin
            if (rx_frame_aligned_i && rx_frame_i.mf) begin
              rx_state_ff <= ovh_pkg::RX_FILL;
              rx_buf_ff   <= put_slot(rx_buf_ff, ovh_pkg::SLOT_FIRST, rx_frame_i.ctl);
              rx_cnt_ff   <= ovh_pkg::SLOT_FIRST + 2'h1;
              loss_cnt_ff <= ovh_pkg::SLOT_FIRST;
            end else begin
              mf_locked_ff <= 1'b0;
              loss_cnt_ff  <= loss_cnt_ff + 2'h1;
              if (loss_cnt_ff == ovh_pkg::SLOT_LAST) begin
                smp_vld_ff  <= 1'b1;
                smp_loss_ff <= 1'b1;
                smp_word_ff <= loss_word;
              end
            end
          end
          ovh_pkg::RX_FILL: begin
            if (!rx_frame_aligned_i || rx_frame_i.mf) begin
              // broken marker: drop the partial word, count as loss
              rx_state_ff  <= ovh_pkg::RX_HUNT;
              mf_locked_ff <= 1'b0;
              smp_vld_ff   <= 1'b1;
              smp_loss_ff  <= 1'b1;
              smp_word_ff  <= loss_word;
            end else begin
              rx_buf_ff <= put_slot(rx_buf_ff, rx_cnt_ff, rx_frame_i.ctl);
              rx_cnt_ff <= rx_cnt_ff + 2'h1;
              if (rx_cnt_ff == ovh_pkg::SLOT_LAST) begin
                rx_state_ff  <= ovh_pkg::RX_HUNT;
                mf_locked_ff <= 1'b1;
                smp_vld_ff   <= 1'b1;
                smp_loss_ff  <= 1'b0;
                smp_word_ff  <= put_slot(rx_buf_ff, rx_cnt_ff, rx_frame_i.ctl);
              end
            end
          end
          default: rx_state_ff <= ovh_pkg::RX_HUNT;
        endcase
      end
    end
  end

  assign mf_locked_o = mf_locked_ff;

  // per-bit persistence filter over three samples
  assign filt_eq = ~(smp_word_ff ^ h1_ff) & ~(h1_ff ^ h2_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h1_ff   <= ovh_pkg::DN_LOSS;
      h2_ff   <= ovh_pkg::DN_LOSS;
      conf_ff <= ovh_pkg::DN_LOSS;
    end else if (smp_vld_ff) begin
      h1_ff   <= smp_word_ff;
      h2_ff   <= h1_ff;
      conf_ff <= (conf_ff & ~filt_eq) | (smp_word_ff & filt_eq);
    end
  end

  // confirmed fields; every copy of a field (one for sync, two, or three for loop request and ack) must agree before acting
  assign cf_wake   = conf_ff[ovh_pkg::D_WAKE1] & conf_ff[ovh_pkg::D_WAKE3];
  assign cf_permit = conf_ff[ovh_pkg::D_PERMIT1] & conf_ff[ovh_pkg::D_PERMIT3];
  assign cf_down   = conf_ff[ovh_pkg::D_DOWN1] & conf_ff[ovh_pkg::D_DOWN3];
  assign cf_sync   = conf_ff[ovh_pkg::D_SYNC];
  assign cf_loop2  = conf_ff[ovh_pkg::D_LREQ1] & conf_ff[ovh_pkg::D_LREQ2]
                   & conf_ff[ovh_pkg::D_LREQ3];
  assign cf_up     = role_net_ff & conf_ff[ovh_pkg::U_UP1] & conf_ff[ovh_pkg::U_UP3];
  assign cf_ack    = role_net_ff & conf_ff[ovh_pkg::U_ACK1] & conf_ff[ovh_pkg::U_ACK2]
                   & conf_ff[ovh_pkg::U_ACK3];
  assign up_flag   = loop2_act_ff ? t_aligned_i : info3_rx_i;

  // loopback is non-transparent, so it forces info0 as well
  assign go_info0 = (cf_down & cf_sync) | cf_loop2;
  assign go_info4 = ~go_info0 & cf_permit & info3_rx_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop2_act_ff <= 1'b0;
      info0_ff     <= 1'b0;
      info2_ff     <= 1'b0;
      info4_ff     <= 1'b0;
    end else begin
      loop2_act_ff <= ~role_net_ff & cf_loop2;
      info0_ff     <= ~role_net_ff & go_info0;
      info4_ff     <= ~role_net_ff & go_info4;
      info2_ff     <= ~role_net_ff & ~go_info0 & ~go_info4 & cf_wake & cf_sync
                      & ~info3_rx_i;
    end
  end

  assign send_info0_o   = info0_ff;
  assign send_info2_o   = info2_ff;
  assign send_info4_o   = info4_ff;
  assign loop2_active_o = loop2_act_ff;
  assign ack_o          = ack_ff;
  assign dat_o          = dat_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_net_mf_start;
    role_net_ff && tx_frame_stb_i && tx_cnt_ff == ovh_pkg::SLOT_FIRST;
  endsequence
  sequence s_usr_mf_start;
    !role_net_ff && tx_frame_stb_i && tx_cnt_ff == ovh_pkg::SLOT_FIRST;
  endsequence

  a_sync_flag_sent:
    assert property (s_net_mf_start |=> tx_word_ff[ovh_pkg::D_SYNC] == $past(rx_frame_aligned_i))
    else $error("sync flag not following alignment");
  a_rbe_next_mf:
    assert property (crc_done_i ##1 (!crc_done_i throughout s_usr_mf_start)
                     |=> tx_word_ff[ovh_pkg::U_RBE] == $past(crc_err_i, 2))
    else $error("error report not in next multiframe");
  a_usr_defaults:
    assert property (s_usr_mf_start |=> tx_word_ff[ovh_pkg::U_Q4:ovh_pkg::U_Q3] == 2'h3
                     && tx_word_ff[ovh_pkg::U_Q2:ovh_pkg::U_Q1] == 2'h3
                     && !tx_word_ff[ovh_pkg::U_FUT1] && !tx_word_ff[ovh_pkg::U_FUT2])
    else $error("spare or future bits wrong");
  a_loop_ack_sent:
    assert property (s_usr_mf_start ##0 loop2_act_ff
                     |=> tx_word_ff[ovh_pkg::U_ACK3:ovh_pkg::U_ACK1] == 3'h7)
    else $error("loop acknowledge not sent");
  a_wake_cmd:
    assert property (cmd_wr && dat_i[ovh_pkg::CMD_ACT]
                     |=> wake_ff && down_ff == $past(dat_i[ovh_pkg::CMD_DOWN]))
    else $error("activate did not set wake request");
  a_loss_default:
    assert property (smp_vld_ff && smp_loss_ff |-> smp_word_ff == loss_word)
    else $error("loss sample not default");
  a_mf_marker:
    assert property (smp_vld_ff && !smp_loss_ff |-> mf_hist_ff == ovh_pkg::MF_WORD)
    else $error("multiframe accepted without marker");
  a_filter_three:
    assert property ($changed(conf_ff) |-> $past(smp_vld_ff)
                     && (((($past(smp_word_ff) ^ conf_ff) | ($past(h1_ff) ^ conf_ff)
                     | ($past(h2_ff) ^ conf_ff)) & (conf_ff ^ $past(conf_ff))) == '0))
    else $error("bit confirmed without three equal samples");
  a_info2_start:
    assert property (!role_net_ff && cf_wake && cf_sync && !cf_down && !cf_loop2
                     && !info3_rx_i |=> send_info2_o)
    else $error("info2 not started");
  a_info4_start:
    assert property (!role_net_ff && cf_permit && info3_rx_i && !go_info0
                     |=> send_info4_o && !send_info2_o)
    else $error("info4 not started");
  a_info0_down:
    assert property (!role_net_ff && cf_down && cf_sync |=> send_info0_o[*1] ##0 !send_info4_o)
    else $error("info0 not sent on down request");

endmodule

/* tb/ovh_peer.sv */
`timescale 1ns/1ps
module ovh_peer (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [15:0]         word_i,
  input  wire logic                aligned_i,
  input  wire ovh_pkg::ovh_frame_t tx_frame_i,
  output logic                     stb_o,
  output ovh_pkg::ovh_frame_t      rx_frame_o,
  output logic                     rx_aligned_o,
  output logic [15:0]              tx_word_o,
  output logic [3:0]               marker_o,
  output logic                     done_o
);
  logic [2:0] cnt_ff;
  logic [1:0] slot_ff;
  logic [1:0] nxt_slot;
  assign nxt_slot = slot_ff + 2'h1;
  // one frame every 8 clocks, one strobe for both directions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff  <= 3'h0;
      slot_ff <= 2'h3;
      stb_o   <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      stb_o  <= (cnt_ff == 3'h7);
      if (cnt_ff == 3'h7) begin
        slot_ff <= nxt_slot;
      end
    end
  end
  // unaligned line toggles, so stale frames never look valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_frame_o   <= '0;
      rx_aligned_o <= 1'b0;
    end else if (cnt_ff == 3'h7) begin
      rx_aligned_o <= aligned_i;
      if (aligned_i) begin
        rx_frame_o.mf  <= (nxt_slot == 2'h0);
        rx_frame_o.ctl <= word_i[4*nxt_slot +: 4];
      end else begin
        rx_frame_o <= ~rx_frame_o;
      end
    end
  end
  // gathers the far multiframe, frame k into bits 4k+3..4k
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_word_o <= '0;
      marker_o  <= '0;
      done_o    <= 1'b0;
    end else begin
      done_o <= (cnt_ff == 3'h1) && (slot_ff == 2'h3);
      if (cnt_ff == 3'h1) begin
        tx_word_o[4*slot_ff +: 4] <= tx_frame_i.ctl;
        marker_o[3 - slot_ff]     <= tx_frame_i.mf;
      end
    end
  end
endmodule

/* tb/test_line_overhead_maintenance_bits.sv */
`timescale 1ns/1ps
module test_line_overhead_maintenance_bits;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
  } note_t;
  typedef struct packed {
    logic [15:0] dn;
    logic        i3;
    logic        ta;
    logic [7:0]  st;
    logic [15:0] up;
  } row_t;
  logic                clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, frame_stb;
  logic [4:0]          adr_i;
  logic [3:0]          sel_i, marker;
  logic [31:0]         dat_i, dat_o, seed;
  ovh_pkg::ovh_frame_t rx_frame, tx_frame_o;
  logic                rx_al, crc_done_i, crc_err_i, info3_rx_i, t_aligned_i;
  logic                send_info0_o, send_info2_o, send_info4_o, loop2_active_o;
  logic                mf_locked_o, aligned, done;
  logic [15:0]         word, tx_word, w0, w1;
  note_t               bus_q[$];
  logic [15:0]         tx_q[$];
  int                  err_count = 0;
  int                  compares = 0;
  logic [7:0]  cmds[7] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h02, 8'h20, 8'h01};
  logic [15:0] exps[7] = '{16'h0109, 16'h030b, 16'h070f, 16'h077f, 16'h047c,
                           16'h040c, 16'h0109};
  row_t rows[7] = '{'{16'h0101, 1'b0, 1'b0, 8'h01, 16'h0c0c},
                    '{16'h0109, 1'b0, 1'b0, 8'h21, 16'h0c0c},
                    '{16'h030b, 1'b1, 1'b0, 8'h41, 16'h0d0d},
                    '{16'h040c, 1'b0, 1'b0, 8'h11, 16'h0c0c},
                    '{16'h0078, 1'b0, 1'b1, 8'h19, 16'h0d7d},
                    '{16'h0078, 1'b0, 1'b0, 8'h19, 16'h0c7c},
                    '{16'h0008, 1'b0, 1'b0, 8'h01, 16'h0c0c}};

  line_overhead_maintenance_bits dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .rx_frame_stb_i(frame_stb), .rx_frame_i(rx_frame), .rx_frame_aligned_i(rx_al),
    .crc_done_i, .crc_err_i, .tx_frame_stb_i(frame_stb), .tx_frame_o,
    .info3_rx_i, .t_aligned_i, .send_info0_o, .send_info2_o, .send_info4_o,
    .loop2_active_o, .mf_locked_o
  );
  ovh_peer peer (
    .clk_i, .rst_i, .word_i(word), .aligned_i(aligned), .tx_frame_i(tx_frame_o),
    .stb_o(frame_stb), .rx_frame_o(rx_frame), .rx_aligned_o(rx_al),
    .tx_word_o(tx_word), .marker_o(marker), .done_o(done)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check_bus(input logic [31:0] got, input note_t n);
    if (n.mask === 32'h0) return;
    compares++;
    if ((got & n.mask) !== (n.exp & n.mask)) begin
      err_count++;
      $display("mismatch t=%0t read %h expected %h", $time, got, n.exp);
    end
  endtask
  task automatic check_tx(input logic [15:0] got, input logic [15:0] e);
    compares++;
    if (got !== e || marker !== ovh_pkg::MF_WORD) begin
      err_count++;
      $display("mismatch t=%0t line word %h marker %h expected %h", $time, got, marker, e);
    end
  endtask
  task automatic check_pins(input logic [7:0] e);
    compares++;
    if ({send_info4_o, send_info2_o, send_info0_o, loop2_active_o, mf_locked_o}
        !== {e[6:3], e[0]}) begin
      err_count++;
      $display("mismatch t=%0t status pins differ from expected %h", $time, e);
    end
  endtask
  // results are matched against the oldest note as they show up
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && bus_q.size() > 0) check_bus(dat_o, bus_q.pop_front());
    if (done === 1'b1 && tx_q.size() > 0) check_tx(tx_word, tx_q.pop_front());
  end

  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                    input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    bus_q.push_back(note_t'{e, m});
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'b0, a, 32'h0, e, m);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 32'h0, 32'h0);
  endtask
  task automatic wait_mf(input int n);
    repeat (n) begin
      do @(posedge clk_i); while (done !== 1'b1);
    end
  endtask
  // push one edge after done so the pending multiframe is not the one judged
  task automatic expect_now(input logic [15:0] e);
    @(posedge clk_i);
    tx_q.push_back(e);
    wait_mf(1);
  endtask
  task automatic expect_tx(input logic [15:0] e);
    wait_mf(1);
    expect_now(e);
  endtask
  // called at a done edge: the pulse lands in the cycle before the next start
  task automatic crc_pulse(input logic e);
    repeat (4) @(posedge clk_i);
    crc_err_i  <= e;
    crc_done_i <= 1'b1;
    @(posedge clk_i);
    crc_done_i <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("counts: compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // whole run is about 2900 clocks
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("mismatch t=%0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    {rst_i, aligned} = 2'b11;
    {cyc_i, stb_i, we_i, crc_done_i, crc_err_i, info3_rx_i, t_aligned_i} = '0;
    adr_i = '0;
    sel_i = 4'hf;
    dat_i = '0;
    word  = '0;
    seed  = 32'h0000000f;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(5'h10, 32'h0c0c, 32'hffffffff);
    rd(5'h0c, 32'h0, 32'hffffffff);
    rd(5'h08, 32'h0, 32'h3ff);
    rd(5'h14, 32'h0, 32'hffffffff);
    $display("test reset done");
    wr(5'h00, 32'h1);
    seed = xs(seed);
    w0 = seed[15:0];
    seed = xs(seed);
    w1 = w0 ^ (seed[15:0] | 16'h0001);
    wait_mf(1);
    word <= w0;
    wait_mf(4);
    rd(5'h0c, {16'h0, w0}, 32'hffff);
    wait_mf(1);
    word <= w1;
    wait_mf(2);
    rd(5'h0c, {16'h0, w0}, 32'hffff);
    wait_mf(1);
    rd(5'h0c, {16'h0, w1}, 32'hffff);
    $display("test confirm done");
    for (int i = 0; i < 7; i++) begin
      wr(5'h04, {24'h0, cmds[i]});
      expect_tx(exps[i]);
    end
    rd(5'h10, 32'h0109, 32'hffff);
    wait_mf(1);
    aligned <= 1'b0;
    expect_tx(16'h0101);
    wait_mf(3);
    rd(5'h0c, 32'h0c0c, 32'hffff);
    rd(5'h08, 32'h0, 32'h1);
    aligned <= 1'b1;
    $display("test network done");
    wr(5'h00, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wait_mf(1);
      word        <= rows[i].dn;
      info3_rx_i  <= rows[i].i3;
      t_aligned_i <= rows[i].ta;
      wait_mf(5);
      rd(5'h08, {24'h0, rows[i].st}, 32'h7b);
      check_pins(rows[i].st);
      expect_tx(rows[i].up);
    end
    $display("test user done");
    wait_mf(1);
    crc_pulse(1'b1);
    expect_now(16'h1c0c);
    wait_mf(1);
    crc_pulse(1'b0);
    expect_now(16'h0c0c);
    $display("test error report done");
    wrap_up();
  end
endmodule
